// ---- shared/pmc_pkg.sv ----
// Package for the transceiver management register bank: offsets, fields, resets, carriers.
// Assumes a single 25 MHz core clock domain shared by every user.
package pmc_pkg;

    // Register addresses on the 5-bit management address
    localparam logic [4:0] PMC_ADDR_CTRL = 5'h00;
    localparam logic [4:0] PMC_ADDR_STAT2 = 5'h11;
    localparam logic [4:0] PMC_ADDR_IRQ_EN = 5'h12;
    localparam logic [4:0] PMC_ADDR_IRQ_ST = 5'h13;
    localparam logic [4:0] PMC_ADDR_IND_CFG = 5'h14;
    localparam logic [4:0] PMC_ADDR_TX_CTRL = 5'h1e;

    // Control register field positions
    localparam int PMC_CTRL_RESET = 15;
    localparam int PMC_CTRL_LOOPBACK = 14;
    localparam int PMC_CTRL_SPEED_LSB = 13;
    localparam int PMC_CTRL_ANEG_EN = 12;
    localparam int PMC_CTRL_PWRDN = 11;
    localparam int PMC_CTRL_ISOLATE = 10;
    localparam int PMC_CTRL_ANEG_RESTART = 9;
    localparam int PMC_CTRL_DUPLEX = 8;
    localparam int PMC_CTRL_COL_TEST = 7;
    localparam int PMC_CTRL_SPEED_MSB = 6;

    // Writable bit masks; everything else reads as zero
    localparam logic [15:0] PMC_CTRL_WMASK = 16'hffc0;
    localparam logic [15:0] PMC_IRQ_EN_WMASK = 16'h00f3;
    localparam logic [15:0] PMC_IND_CFG_WMASK = 16'hfffe;
    localparam logic [15:0] PMC_TX_CTRL_WMASK = 16'h1e00;

    // Reset values; the strapped control bits reset to zero and are filled later
    localparam logic [15:0] PMC_CTRL_RST = 16'h0000;
    localparam logic [15:0] PMC_IRQ_EN_RST = 16'h0000;
    localparam logic [15:0] PMC_IND_CFG_RST = 16'h0000;
    localparam logic [15:0] PMC_TX_CTRL_RST = 16'h0000;

    // Edges the strap synchroniser needs after reset release before its levels are real
    localparam logic [1:0] PMC_STRAP_SETTLE = 2'h2;

    // Speed encodings {msb, lsb}
    typedef enum logic [1:0]
    {
        PMC_SPD_10 = 2'h0,
        PMC_SPD_100 = 2'h1,
        PMC_SPD_1000 = 2'h2,
        PMC_SPD_RSVD = 2'h3
    } pmc_speed_e;

    // Strap levels caught at reset release
    typedef struct packed
    {
        logic aneg_en;
        logic speed_100;
        logic full_duplex;
    } pmc_strap_s;

    // Control outputs to the media-side logic
    typedef struct packed
    {
        logic speed_100;
        logic speed_bad;
        logic full_duplex;
        logic aneg_en;
        logic loopback;
        logic power_down;
        logic isolate;
        logic col_test;
    } pmc_ctrl_s;

endpackage : pmc_pkg

// ---- logic/pmc_regs.sv ----
// Management register bank: basic control plus the vendor registers 17..20 and 30.
// Assumes a management frame engine on core_clk_i that presents a whole 16-bit write
// as one strobe at frame end, and media logic that acknowledges reset and restart.
`timescale 1ns/1ns
`default_nettype none

module pmc_regs
    import pmc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] config_strap_pins_i,
    input wire logic mgmt_wr_i,
    input wire logic [4:0] mgmt_addr_i,
    input wire logic [15:0] mgmt_wdata_i,
    output logic [15:0] mgmt_rdata_o,
    input wire logic [15:0] secondary_status_i,
    input wire logic [15:0] irq_status_i,
    input wire logic soft_reset_done_i,
    input wire logic aneg_restart_done_i,
    output logic soft_reset_req_o,
    output logic aneg_restart_req_o,
    output pmc_ctrl_s ctrl_o,
    output logic [15:0] irq_enable_o,
    output logic [15:0] indicator_config_o,
    output logic [15:0] transmit_control_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Strap capture
    logic [2:0] strap_meta_q;
    logic [2:0] strap_sync_q;
    logic strap_armed_q;
    pmc_strap_s strap_q;

    // Two-flop synchroniser on the straps; only the second stage is looked at
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            strap_meta_q <= 3'h0;
            strap_sync_q <= 3'h0;
        end
        else
        begin
            strap_meta_q <= config_strap_pins_i;
            strap_sync_q <= strap_meta_q;
        end
    end

    // Straps latched once, on the third edge after release, when the synchroniser holds real levels
    logic [1:0] strap_wait_q;
    logic strap_load;

    // Single-cycle load window; the control word and the strap copy both use it, so the
    // two take the same pin levels unless, in that cycle, a soft_reset_done_i pulse reloads the word from the cleared copy or a control write replaces it
    assign strap_load = !strap_armed_q && (strap_wait_q == PMC_STRAP_SETTLE);

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            strap_wait_q <= 2'h0;
            strap_armed_q <= 1'b0;
            strap_q <= '0;
        end
        else if (!strap_armed_q)
        begin
            strap_wait_q <= strap_wait_q + 2'h1;
            if (strap_load)
            begin
                strap_armed_q <= 1'b1;
                strap_q <= strap_sync_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write decode
    // Only whole-word strobes are decoded; reads have no side effects, so the manager
    // may repeat a read of any address freely
    wire wr_ctrl = mgmt_wr_i && (mgmt_addr_i == PMC_ADDR_CTRL);
    wire wr_irq_en = mgmt_wr_i && (mgmt_addr_i == PMC_ADDR_IRQ_EN);
    wire wr_ind = mgmt_wr_i && (mgmt_addr_i == PMC_ADDR_IND_CFG);
    wire wr_tx = mgmt_wr_i && (mgmt_addr_i == PMC_ADDR_TX_CTRL);

    ////////////////////////////////////////////////////////////////////////////////
    // Control register
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [15:0] ctrl_wr_val;

    // Low six bits are dropped so stray writes cannot show up on reads
    assign ctrl_wr_val = mgmt_wdata_i & PMC_CTRL_WMASK;

    // Drops the strap levels into the three strapped control bits of a word; shared by the
    // first load after reset and by the software reset reload, so both follow one map
    function automatic logic [15:0] merge_straps(input logic [15:0] word, input pmc_strap_s s);
        logic [15:0] r;
        r = word;
        r[PMC_CTRL_ANEG_EN] = s.aneg_en;
        r[PMC_CTRL_SPEED_LSB] = s.speed_100;
        r[PMC_CTRL_DUPLEX] = s.full_duplex;
        return r;
    endfunction : merge_straps

    // Whole-word load at frame end; straps drop in once; done pulses clear the
    // self-clearing bits, but a new write of one in the same cycle wins
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (strap_load)
        begin
            ctrl_d = merge_straps(ctrl_q, pmc_strap_s'(strap_sync_q));
        end
        if (soft_reset_done_i)
        begin
            ctrl_d = merge_straps(PMC_CTRL_RST, strap_q);
        end
        if (aneg_restart_done_i)
        begin
            ctrl_d[PMC_CTRL_ANEG_RESTART] = 1'b0;
        end
        // A write is applied last so its word lands whole, never merged with a pulse
        if (wr_ctrl)
        begin
            ctrl_d = ctrl_wr_val;
        end
    end

    // Reset clears the strapped bits too; they are filled three edges after release
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ctrl_q <= PMC_CTRL_RST;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Vendor read/write registers
    logic [15:0] irq_en_q;
    logic [15:0] ind_q;
    logic [15:0] tx_q;

    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            irq_en_q <= PMC_IRQ_EN_RST;
            ind_q <= PMC_IND_CFG_RST;
            tx_q <= PMC_TX_CTRL_RST;
        end
        else
        begin
            // Reserved bits are dropped here, so the read path needs no second mask
            if (wr_irq_en)
            begin
                irq_en_q <= mgmt_wdata_i & PMC_IRQ_EN_WMASK;
            end
            if (wr_ind)
            begin
                ind_q <= mgmt_wdata_i & PMC_IND_CFG_WMASK;
            end
            if (wr_tx)
            begin
                tx_q <= mgmt_wdata_i & PMC_TX_CTRL_WMASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded control outputs
    pmc_speed_e speed_sel;
    assign speed_sel = pmc_speed_e'({ctrl_q[PMC_CTRL_SPEED_MSB], ctrl_q[PMC_CTRL_SPEED_LSB]});

    // Unsupported and reserved patterns fall back to 10 Mbps and are flagged
    assign ctrl_o.speed_100 = (speed_sel == PMC_SPD_100);
    assign ctrl_o.speed_bad = (speed_sel == PMC_SPD_1000) || (speed_sel == PMC_SPD_RSVD);
    assign ctrl_o.full_duplex = ctrl_q[PMC_CTRL_DUPLEX];
    assign ctrl_o.aneg_en = ctrl_q[PMC_CTRL_ANEG_EN];
    assign ctrl_o.loopback = ctrl_q[PMC_CTRL_LOOPBACK];
    assign ctrl_o.power_down = ctrl_q[PMC_CTRL_PWRDN];
    assign ctrl_o.isolate = ctrl_q[PMC_CTRL_ISOLATE];
    assign ctrl_o.col_test = ctrl_q[PMC_CTRL_COL_TEST];
    assign soft_reset_req_o = ctrl_q[PMC_CTRL_RESET];
    assign aneg_restart_req_o = ctrl_q[PMC_CTRL_ANEG_RESTART];
    assign irq_enable_o = irq_en_q;
    assign indicator_config_o = ind_q;
    assign transmit_control_o = tx_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero
    always_comb
    begin
        case (mgmt_addr_i)
            PMC_ADDR_CTRL: mgmt_rdata_o = ctrl_q;
            PMC_ADDR_STAT2: mgmt_rdata_o = secondary_status_i;
            PMC_ADDR_IRQ_EN: mgmt_rdata_o = irq_en_q;
            PMC_ADDR_IRQ_ST: mgmt_rdata_o = irq_status_i;
            PMC_ADDR_IND_CFG: mgmt_rdata_o = ind_q;
            PMC_ADDR_TX_CTRL: mgmt_rdata_o = tx_q;
            default: mgmt_rdata_o = 16'h0000;
        endcase
    end

endmodule : pmc_regs

`default_nettype wire

// ---- bench/pmc_mac_model.sv ----
// Station manager model: whole-word register writes and address-driven reads.
// Assumes the bench calls its tasks from one process, off the rising edge.
`timescale 1ns/1ns
`default_nettype none
module pmc_mac_model
    import pmc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic [15:0] rdata_i,
    output logic wr_o,
    output logic [4:0] addr_o,
    output logic [15:0] wdata_o
);
    // Idle bus at time zero
    initial
    begin
        wr_o = 1'b0;
        addr_o = 5'h1f;
        wdata_o = 16'h0000;
    end
    // One-cycle strobe; data is scrambled once released so stale values never pass
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge core_clk_i);
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = (a == PMC_ADDR_CTRL) ? (d & 16'hffc0) : d;
        @(negedge core_clk_i);
        wr_o = 1'b0;
        wdata_o = ~wdata_o;
    endtask : wr
    // Read data is combinational off the held address; it is taken at the next rising
    // edge, where the design sees the same address
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge core_clk_i);
        addr_o = a;
        @(posedge core_clk_i);
        d = rdata_i;
    endtask : rd
endmodule : pmc_mac_model
`default_nettype wire

// ---- bench/pmc_regs_asserts.sv ----
// Checker on the register bank ports.
// Assumes straps are held steady around reset release.
`timescale 1ns/1ns
`default_nettype none
module pmc_regs_asserts
    import pmc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] config_strap_pins_i,
    input wire logic mgmt_wr_i,
    input wire logic [4:0] mgmt_addr_i,
    input wire logic [15:0] mgmt_wdata_i,
    input wire logic [15:0] mgmt_rdata_o,
    input wire logic soft_reset_done_i,
    input wire logic aneg_restart_done_i,
    input wire logic soft_reset_req_o,
    input wire logic aneg_restart_req_o,
    input wire pmc_ctrl_s ctrl_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic cw = mgmt_wr_i && (mgmt_addr_i == PMC_ADDR_CTRL);
    logic [15:0] pw;
    // Write data bus as sampled on the previous edge, so consequents can look at single bits of it
    always_ff @(posedge core_clk_i) pw <= mgmt_wdata_i;
    ////////////////////////////////////////////////////////////////
    property p_speed;
        mgmt_addr_i == PMC_ADDR_CTRL |-> ctrl_o.speed_100 == (mgmt_rdata_o[13] & ~mgmt_rdata_o[6])
            && ctrl_o.speed_bad == mgmt_rdata_o[6];
    endproperty
    a_speed: assert property (p_speed) else $error("speed decode wrong");
    property p_col;
        cw |=> ctrl_o.col_test == pw[7];
    endproperty
    a_col: assert property (p_col) else $error("collision test bit wrong");
    property p_strap;
        $fell(sys_rst_i) |-> ##3 {ctrl_o.aneg_en, mgmt_rdata_o[13] | ctrl_o.speed_100,
            ctrl_o.full_duplex} == config_strap_pins_i;
    endproperty
    a_strap: assert property (p_strap) else $error("strap defaults wrong");
    property p_sc;
        (!cw && soft_reset_done_i |=> !soft_reset_req_o)
            and (!cw && aneg_restart_done_i |=> !aneg_restart_req_o);
    endproperty
    a_sc: assert property (p_sc) else $error("request did not clear");
    property p_set;
        cw |=> soft_reset_req_o == pw[15] && aneg_restart_req_o == pw[9];
    endproperty
    a_set: assert property (p_set) else $error("request not raised");
    property p_atom;
        cw |=> {ctrl_o.full_duplex, ctrl_o.loopback, ctrl_o.isolate} == {pw[8], pw[14], pw[10]};
    endproperty
    a_atom: assert property (p_atom) else $error("control word not applied whole");
    c_rst: cover property (cw && mgmt_wdata_i[15]);
    c_an: cover property (aneg_restart_done_i && aneg_restart_req_o);
    c_bad: cover property (cw && mgmt_wdata_i[6]);
endmodule : pmc_regs_asserts
bind pmc_regs pmc_regs_asserts u_chk (.core_clk_i, .sys_rst_i, .config_strap_pins_i,
    .mgmt_wr_i, .mgmt_addr_i, .mgmt_wdata_i, .mgmt_rdata_o, .soft_reset_done_i,
    .aneg_restart_done_i, .soft_reset_req_o, .aneg_restart_req_o, .ctrl_o);
`default_nettype wire

// ---- bench/pmc_regs_bench.sv ----
// Bench: manager-driven writes and reads checked against an integer model.
// Assumes the design, its checker and the manager model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module pmc_regs_bench
    import pmc_pkg::*;
;
    logic core_clk_i = 1'b0, sys_rst_i = 1'b1, srd = 1'b0, ard = 1'b0;
    logic [2:0] strp;
    logic [15:0] st2, ist, rd, w;
    logic [31:0] seed = 32'h0be7;
    logic [4:0] ta [6] = '{5'h11, 5'h12, 5'h13, 5'h14, 5'h1e, 5'h03};
    wire logic wr, srq, arq;
    wire logic [4:0] ad;
    wire logic [15:0] wd, rdat, ien, icf, txc;
    wire pmc_ctrl_s ctl;
    int miscompares = 0, tests_run = 0, m [32];
    // 25 MHz clock
    always #20 core_clk_i = ~core_clk_i;
    pmc_mac_model mac (.core_clk_i, .rdata_i(rdat), .wr_o(wr), .addr_o(ad), .wdata_o(wd));
    pmc_regs DUT (.core_clk_i, .sys_rst_i, .config_strap_pins_i(strp), .mgmt_wr_i(wr),
        .mgmt_addr_i(ad), .mgmt_wdata_i(wd), .mgmt_rdata_o(rdat), .secondary_status_i(st2),
        .irq_status_i(ist), .soft_reset_done_i(srd), .aneg_restart_done_i(ard),
        .soft_reset_req_o(srq), .aneg_restart_req_o(arq), .ctrl_o(ctl), .irq_enable_o(ien),
        .indicator_config_o(icf), .transmit_control_o(txc));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : nxt
    function automatic int sp();
        return int'(strp[2]) << 12 | int'(strp[1]) << 13 | int'(strp[0]) << 8;
    endfunction : sp
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (e !== g)
        begin
            miscompares++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [4:0] a);
        mac.rd(a, rd);
        chk(16'(m[a]), rd);
    endtask : rchk
    task automatic pulse(ref logic s);
        @(negedge core_clk_i) s = 1'b1;
        @(negedge core_clk_i) s = 1'b0;
    endtask : pulse
    task automatic summarize();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // Watchdog: the run needs well under a thousand cycles
    initial
    begin
        #50000 miscompares++;
        summarize();
    end
    // Main sequence: reset defaults, speed codes, vendor registers, self-clearing bits
    initial
    begin
        strp = 3'(nxt());
        st2 = 16'(nxt());
        ist = 16'(nxt());
        m = '{default: 0};
        repeat (12) @(posedge core_clk_i);
        @(negedge core_clk_i) sys_rst_i = 1'b0;
        m[0] = sp();
        m[17] = st2;
        m[19] = ist;
        repeat (4) @(negedge core_clk_i);
        foreach (m[i]) rchk(5'(i));
        for (int s = 0; s < 4; s++)
        begin
            w = 16'(nxt()) & 16'h5dbf;
            w[6] = s[1];
            w[13] = s[0];
            mac.wr(PMC_ADDR_CTRL, w);
            m[0] = w & PMC_CTRL_WMASK;
            rchk(PMC_ADDR_CTRL);
            chk(16'(ctl), 16'({s == 1, s[1], w[8], w[12], w[14], w[11], w[10], w[7]}));
        end
        foreach (ta[i])
        begin
            w = 16'(nxt());
            mac.wr(ta[i], w);
            m[ta[i]] = ta[i] == 18 ? w & PMC_IRQ_EN_WMASK : ta[i] == 20 ? w & PMC_IND_CFG_WMASK
                : ta[i] == 30 ? w & PMC_TX_CTRL_WMASK : m[ta[i]];
        end
        foreach (ta[i]) rchk(ta[i]);
        chk(16'(m[18]), ien);
        chk(16'(m[20]), icf);
        chk(16'(m[30]), txc);
        mac.wr(PMC_ADDR_CTRL, 16'h8200);
        m[0] = 16'h8200;
        chk(16'({srq, arq}), 16'h0003);
        pulse(ard);
        m[0] = 16'h8000;
        rchk(PMC_ADDR_CTRL);
        pulse(srd);
        m[0] = sp();
        rchk(PMC_ADDR_CTRL);
        // Second reset with new strap levels: defaults must follow the pins again
        @(negedge core_clk_i);
        strp = 3'(nxt());
        sys_rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        m[0] = sp();
        m[18] = 0;
        m[20] = 0;
        m[30] = 0;
        repeat (4) @(negedge core_clk_i);
        foreach (m[i]) rchk(5'(i));
        summarize();
    end
endmodule : pmc_regs_bench
`default_nettype wire
